/* File: comm_idle_timeout_monitor.sv */
// How it works
// - Device powers down when idle time reaches the power-down period.
// - Power-down code 0 disables; 1..13 select 0.1 s to 1 h; 14-15 reserved.
// - Device sets the silence fault when idle time reaches the fault period.
// - Fault code uses the same table; 0 disables, 14-15 reserved.
// - One 24-bit idle up-counter advances on each 4 kHz tick until it saturates at all ones.
// - The single counter is the time base for both thresholds.
// - Writing the counter register loads the running counter.
// - Reading the counter returns the live count.
// - Power-down timeout or software request sets the logic power-down flag.
//
// Chosen here: the APB register port.
`timescale 1ns/10ps
module comm_idle_timeout_monitor #(
  parameter int tick_div = idle_mon_pkg::TICK_DIV
) (
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Link events.
  input  wire logic        frame_valid,
  input  wire logic        powerdown_req,
  // Outputs.
  output logic             irq,
  output logic             shutdown_req,
  output logic             link_silence_fault,
  output logic             logic_powerdown_flag
);

  localparam int CW = idle_mon_pkg::CNT_W;
  localparam int EW = idle_mon_pkg::EV_W;

  typedef struct packed {
    logic [7:0]    cfg;
    logic [CW-1:0] count;
    logic          hold_off;
    logic [EW-1:0] status;
    logic [EW-1:0] mask;
    logic          pd_flag;
    logic          shutdown;
    logic          irq;
    logic          ready;
    logic          slverr;
    logic [31:0]   rdata;
  } mon_state_s;

  mon_state_s s;
  mon_state_s next_s;

  idle_tick_if tick_bus ();

  idle_tick_divider #(
    .div (tick_div)
  ) u_div (
    .pclk    (pclk),
    .presetn (presetn),
    .t       (tick_bus)
  );

  logic          tick;
  logic [5:0]    idx;
  logic          aligned;
  logic          hit;
  logic          wr;
  logic          setup;
  logic [CW-1:0] thr_f;
  logic [CW-1:0] thr_p;
  logic [CW-1:0] inc;
  logic          load;
  logic          clr;
  logic          bump;
  logic          fault_hit;
  logic          pd_hit;
  logic          pd_evt;
  logic [EW-1:0] w1c;
  logic [EW-1:0] events;

  assign tick    = tick_bus.tick;
  assign idx     = paddr[7:2];
  assign aligned = (paddr[1:0] == 2'h0);
  assign setup   = psel && !penable;
  assign wr      = psel && penable && s.ready && pwrite;

  always_comb begin
    case (idx)
      idle_mon_pkg::IDX_CONFIG,
      idle_mon_pkg::IDX_COUNT,
      idle_mon_pkg::IDX_STATUS,
      idle_mon_pkg::IDX_MASK,
      idle_mon_pkg::IDX_CTRL,
      idle_mon_pkg::IDX_SHDN: hit = aligned;
      default:                hit = 1'b0;
    endcase
  end

  // Both thresholds are compared against the one shared counter.
  assign thr_f = idle_mon_pkg::period_ticks(
    s.cfg[idle_mon_pkg::FLT_MSB:idle_mon_pkg::FLT_LSB]);
  assign thr_p = idle_mon_pkg::period_ticks(
    s.cfg[idle_mon_pkg::PD_MSB:idle_mon_pkg::PD_LSB]);
  assign inc   = s.count + 1'b1;
  assign load  = wr && hit && (idx == idle_mon_pkg::IDX_COUNT);
  assign clr   = frame_valid && !s.hold_off;
  // The counter saturates so a threshold is never crossed twice.
  assign bump  = tick && !load && !clr && (s.count != '1);
  assign fault_hit = bump && (thr_f != '0) && (inc == thr_f);
  assign pd_hit    = bump && (thr_p != '0) && (inc == thr_p);
  assign pd_evt    = pd_hit || powerdown_req;

  always_comb begin
    events = '0;
    events[idle_mon_pkg::ST_FAULT] = fault_hit;
    events[idle_mon_pkg::ST_PDOWN] = pd_evt;
    w1c = '0;
    if (wr && hit && idx == idle_mon_pkg::IDX_STATUS) begin
      w1c = pwdata[EW-1:0];
    end
  end

  always_comb begin
    next_s = s;
    next_s.ready  = setup;
    next_s.slverr = 1'b0;
    if (setup) begin
      next_s.slverr = !hit;
      next_s.rdata  = 32'h0000_0000;
      if (hit) begin
        case (idx)
          idle_mon_pkg::IDX_CONFIG: next_s.rdata[7:0]    = s.cfg;
          idle_mon_pkg::IDX_COUNT:  next_s.rdata[CW-1:0] = s.count;
          idle_mon_pkg::IDX_STATUS: next_s.rdata[EW-1:0] = s.status;
          idle_mon_pkg::IDX_MASK:   next_s.rdata[EW-1:0] = s.mask;
          idle_mon_pkg::IDX_CTRL:
            next_s.rdata[idle_mon_pkg::CTRL_HOLD] = s.hold_off;
          idle_mon_pkg::IDX_SHDN:
            next_s.rdata[idle_mon_pkg::SHDN_FLAG] = s.pd_flag;
          default:                  next_s.rdata = 32'h0000_0000;
        endcase
      end
    end
    if (wr && hit) begin
      case (idx)
        idle_mon_pkg::IDX_CONFIG: next_s.cfg      = pwdata[7:0];
        idle_mon_pkg::IDX_MASK:   next_s.mask     = pwdata[EW-1:0];
        idle_mon_pkg::IDX_CTRL:
          next_s.hold_off = pwdata[idle_mon_pkg::CTRL_HOLD];
        default:                  next_s.cfg      = s.cfg;
      endcase
    end
    if (load) begin
      next_s.count = pwdata[CW-1:0];
    end else if (clr) begin
      next_s.count = '0;
    end else if (bump) begin
      next_s.count = inc;
    end
    // A new event wins over a clear written in the same cycle.
    next_s.status = (s.status & ~w1c) | events;
    if (pd_evt) begin
      next_s.pd_flag  = 1'b1;
      next_s.shutdown = 1'b1;
    end
    next_s.irq = |(next_s.status & next_s.mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s          <= '0;
      s.cfg      <= idle_mon_pkg::CONFIG_RST;
      s.count    <= idle_mon_pkg::COUNT_RST;
      s.status   <= idle_mon_pkg::EV_RST;
      s.mask     <= idle_mon_pkg::EV_RST;
    end else begin
      s <= next_s;
    end
  end

  assign prdata               = s.rdata;
  assign pready               = s.ready;
  assign pslverr              = s.slverr;
  assign irq                  = s.irq;
  assign shutdown_req         = s.shutdown;
  assign link_silence_fault   = s.status[idle_mon_pkg::ST_FAULT];
  assign logic_powerdown_flag = s.pd_flag;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_pd_on_expiry: assert property (pd_hit |=> shutdown_req &&
    logic_powerdown_flag)
    else $error("Power-down expiry did not raise shutdown.");

  a_pd_code_off: assert property (
    (s.cfg[idle_mon_pkg::PD_MSB:idle_mon_pkg::PD_LSB] == 4'h0 ||
     s.cfg[idle_mon_pkg::PD_MSB:idle_mon_pkg::PD_LSB] > 4'hD) &&
    !powerdown_req && !shutdown_req |=> !shutdown_req)
    else $error("Disabled power-down period still shut down.");

  a_fault_raise: assert property (fault_hit |=> link_silence_fault)
    else $error("Silence fault missing after threshold.");

  a_fault_code1: assert property (
    s.cfg[idle_mon_pkg::FLT_MSB:idle_mon_pkg::FLT_LSB] == 4'h1 &&
    bump && inc == CW'(idle_mon_pkg::T_C1_MS * idle_mon_pkg::TICKS_PER_MS)
    |-> fault_hit)
    else $error("Fault code 1 did not fire at 400 ticks.");

  a_count_step: assert property (
    bump |=> s.count == $past(s.count) + 1'b1)
    else $error("Idle counter did not advance on tick.");

  a_shared_base: assert property (
    fault_hit && thr_f == thr_p |-> pd_hit)
    else $error("Equal thresholds fired apart.");

  a_count_load: assert property (
    load |=> s.count == $past(pwdata[CW-1:0]))
    else $error("Counter write did not load.");

  a_count_read: assert property (
    setup && hit && idx == idle_mon_pkg::IDX_COUNT ##1 psel && penable
    |-> prdata == {8'h00, $past(s.count)})
    else $error("Counter read returned wrong value.");

  a_pd_flag_set: assert property (
    powerdown_req |=> logic_powerdown_flag ##1 logic_powerdown_flag)
    else $error("Power-down flag not held.");

  a_frame_clear: assert property (clr && !load |=> s.count == '0)
    else $error("Valid frame did not clear the counter.");

  a_fault_sticky: assert property (
    link_silence_fault && !(wr && idx == idle_mon_pkg::IDX_STATUS &&
    pwdata[idle_mon_pkg::ST_FAULT]) |=> link_silence_fault)
    else $error("Silence fault dropped without a clear.");

  // Thresholds, stickiness, counter holding and the bus answer.
  a_pd_code1: assert property (
    s.cfg[idle_mon_pkg::PD_MSB:idle_mon_pkg::PD_LSB] == 4'h1 &&
    bump && inc == CW'(idle_mon_pkg::T_C1_MS * idle_mon_pkg::TICKS_PER_MS)
    |-> pd_hit)
    else $error("Power-down code 1 did not fire at 400 ticks.");

  a_fault_code_off: assert property (
    (s.cfg[idle_mon_pkg::FLT_MSB:idle_mon_pkg::FLT_LSB] == 4'h0 ||
     s.cfg[idle_mon_pkg::FLT_MSB:idle_mon_pkg::FLT_LSB] > 4'hD)
    |-> !fault_hit)
    else $error("Disabled fault period still raised the fault.");

  a_cfg_write: assert property (
    wr && hit && idx == idle_mon_pkg::IDX_CONFIG |=>
    s.cfg == $past(pwdata[7:0]))
    else $error("Timeout config write did not land.");

  a_shutdown_held: assert property (
    shutdown_req |=> shutdown_req)
    else $error("Shutdown request dropped before reset.");

  a_flag_held: assert property (
    logic_powerdown_flag |=> logic_powerdown_flag)
    else $error("Power-down flag dropped before reset.");

  a_pd_status: assert property (
    pd_evt |=> s.status[idle_mon_pkg::ST_PDOWN])
    else $error("Power-down event not recorded in status.");

  a_count_idle: assert property (
    !tick && !load && !clr |=> s.count == $past(s.count))
    else $error("Idle counter moved without a tick.");

  a_count_sat: assert property (
    s.count == '1 && !load && !clr |=> s.count == '1)
    else $error("Idle counter wrapped past its maximum.");

  a_hold_frame: assert property (
    frame_valid && s.hold_off && !load && !tick |=>
    s.count == $past(s.count))
    else $error("Frame cleared the counter while held off.");

  a_fault_once: assert property (
    fault_hit |=> !fault_hit)
    else $error("Fault threshold hit twice in a row.");

  a_fault_clear: assert property (
    w1c[idle_mon_pkg::ST_FAULT] && !fault_hit |=> !link_silence_fault)
    else $error("Silence fault not cleared by a one write.");

  a_irq_level: assert property (
    irq == |(s.status & s.mask))
    else $error("Interrupt does not follow unmasked status.");

  a_ready_once: assert property (
    setup |=> pready ##1 !pready)
    else $error("Ready did not stand for one access cycle.");

  a_unmapped_err: assert property (
    setup && !hit |=> pslverr && prdata == 32'h0000_0000)
    else $error("Unmapped access answered without an error.");

  c_fault: cover property (fault_hit ##1 link_silence_fault);
  c_pd_timeout: cover property (pd_hit ##1 shutdown_req);
  c_frame_clear: cover property (clr && s.count != '0);
  c_w1c_race: cover property (fault_hit && w1c[idle_mon_pkg::ST_FAULT]);
  c_pd_request: cover property (powerdown_req ##1 logic_powerdown_flag);

endmodule

/* File: comm_idle_timeout_monitor_tb.sv */
`timescale 1ns/10ps
module comm_idle_timeout_monitor_tb;
  localparam int TPM = 4;
  logic        pclk = 1'b0;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic        powerdown_req;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        frame_valid;
  logic        irq;
  logic        shutdown_req;
  logic        link_silence_fault;
  logic        logic_powerdown_flag;
  logic [31:0] r;
  logic        e;
  int          n;
  int          fails;
  int          num_checks;
  int          ms[14] = '{0, 100, 500, 1000, 2000, 5000, 10000, 30000,
                          60000, 120000, 300000, 600000, 1800000, 3600000};

  always #50 pclk = ~pclk;

  comm_idle_timeout_monitor #(.tick_div(4)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .frame_valid(frame_valid),
    .powerdown_req(powerdown_req), .irq(irq), .shutdown_req(shutdown_req),
    .link_silence_fault(link_silence_fault),
    .logic_powerdown_flag(logic_powerdown_flag));

  host_link_model host (.pclk(pclk), .frame_valid(frame_valid));

  task print_verdict;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [5:0] idx,
                     input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {idx, 2'b00};
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Ready, read data and error are taken at the edge that ends the access.
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      fails++;
      print_verdict();
    end
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    check(r, exp);
  endtask

  // Waits for the fault (0) or the shutdown request (1), counting cycles.
  task automatic wait_hi(input int k, input int lim);
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while ((k == 0 ? link_silence_fault : shutdown_req) !== 1'b1
               && n < lim);
    if (n >= lim) begin
      fails++;
      print_verdict();
    end
  endtask

  task do_reset;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  initial begin
    presetn       <= 1'b0;
    psel          <= 1'b0;
    penable       <= 1'b0;
    pwrite        <= 1'b0;
    paddr         <= 8'h00;
    pwdata        <= 32'h0000_0000;
    powerdown_req <= 1'b0;
    fails = 0;
    num_checks = 0;
    do_reset();
    rd(idle_mon_pkg::IDX_CONFIG, 32'h0);
    rd(idle_mon_pkg::IDX_STATUS, 32'h0);
    apb(1'b0, 6'h3F, 32'h0);
    check(r, 32'h0);
    check(32'(e), 32'h1);
    apb(1'b1, idle_mon_pkg::IDX_CTRL, 32'h1);
    apb(1'b1, idle_mon_pkg::IDX_COUNT, 32'hFFFFFF);
    rd(idle_mon_pkg::IDX_COUNT, 32'hFFFFFF);
    host.send_frame(2);
    rd(idle_mon_pkg::IDX_COUNT, 32'hFFFFFF);
    apb(1'b1, idle_mon_pkg::IDX_CTRL, 32'h0);
    host.send_frame(0);
    apb(1'b0, idle_mon_pkg::IDX_COUNT, 32'h0);
    check(32'(r <= 32'h3), 32'h1);
    // Power-down period longer than the fault period.
    apb(1'b1, idle_mon_pkg::IDX_CONFIG, 32'h21);
    host.send_frame(0);
    wait_hi(0, 2000);
    check(32'(n >= 1590 && n <= 1610), 32'h1);
    check(32'(irq), 32'h0);
    apb(1'b1, idle_mon_pkg::IDX_MASK, 32'h1);
    @(negedge pclk);
    check(32'(irq), 32'h1);
    rd(idle_mon_pkg::IDX_STATUS, 32'h1);
    host.send_frame(1);
    @(negedge pclk);
    check(32'(link_silence_fault), 32'h1);
    apb(1'b1, idle_mon_pkg::IDX_STATUS, 32'h1);
    @(negedge pclk);
    check(32'(link_silence_fault), 32'h0);
    check(32'(irq), 32'h0);
    host.send_frame(0);
    wait_hi(1, 9000);
    check(32'(n >= 7990 && n <= 8010), 32'h1);
    check(32'(logic_powerdown_flag), 32'h1);
    rd(idle_mon_pkg::IDX_SHDN, 32'h80);
    do_reset();
    apb(1'b1, idle_mon_pkg::IDX_MASK, 32'h1);
    for (int c = 1; c <= 13; c++) begin
      apb(1'b1, idle_mon_pkg::IDX_CONFIG, 32'(c));
      apb(1'b1, idle_mon_pkg::IDX_COUNT, 32'(ms[c] * TPM - 3));
      wait_hi(0, 40);
      check(32'(irq), 32'h1);
      apb(1'b1, idle_mon_pkg::IDX_STATUS, 32'h1);
      repeat (12) @(negedge pclk);
      check(32'(link_silence_fault), 32'h0);
    end
    foreach (ms[i]) begin
      if (i == 0 || i > 11) begin
        apb(1'b1, idle_mon_pkg::IDX_CONFIG, 32'((i == 0 ? 0 : i + 2) * 17));
        apb(1'b1, idle_mon_pkg::IDX_COUNT, 32'h0);
        repeat (30) @(negedge pclk);
        check(32'(link_silence_fault), 32'h0);
        check(32'(shutdown_req), 32'h0);
      end
    end
    @(posedge pclk);
    powerdown_req <= 1'b1;
    @(posedge pclk);
    powerdown_req <= 1'b0;
    @(negedge pclk);
    check(32'(logic_powerdown_flag), 32'h1);
    rd(idle_mon_pkg::IDX_STATUS, 32'h2);
    check(32'(irq), 32'h0);
    check(32'(shutdown_req), 32'h1);
    apb(1'b1, idle_mon_pkg::IDX_MASK, 32'h2);
    @(negedge pclk);
    check(32'(irq), 32'h1);
    print_verdict();
  end
endmodule

/* File: host_link_model.sv */
`timescale 1ns/10ps
module host_link_model (
  // Clock.
  input wire logic pclk,
  // Frame strobe to the device.
  output logic     frame_valid
);
  initial frame_valid = 1'b0;

  // One valid frame is a single-cycle strobe after some idle cycles.
  task automatic send_frame(input int gap);
    repeat (gap + 1) @(posedge pclk);
    frame_valid <= 1'b1;
    @(posedge pclk);
    frame_valid <= 1'b0;
  endtask
endmodule

/* File: idle_mon_pkg.sv */
package idle_mon_pkg;

  // Clock and tick rates.
  localparam int CLK_HZ        = 10_000_000;
  localparam int TICK_HZ       = 4_000;
  localparam int TICK_DIV      = CLK_HZ / TICK_HZ;
  localparam int TICKS_PER_MS  = TICK_HZ / 1000;
  localparam int TICK_W        = 12;
  localparam int CNT_W         = 24;

  // Register indices; the byte address is four times the index.
  localparam logic [5:0] IDX_CONFIG = 6'h28;
  localparam logic [5:0] IDX_COUNT  = 6'h29;
  localparam logic [5:0] IDX_STATUS = 6'h2C;
  localparam logic [5:0] IDX_MASK   = 6'h2D;
  localparam logic [5:0] IDX_CTRL   = 6'h2E;
  localparam logic [5:0] IDX_SHDN   = 6'h2F;
  localparam int         ADDR_W     = 8;

  // Field positions.
  localparam int PD_MSB     = 7;
  localparam int PD_LSB     = 4;
  localparam int FLT_MSB    = 3;
  localparam int FLT_LSB    = 0;
  localparam int ST_FAULT   = 0;
  localparam int ST_PDOWN   = 1;
  localparam int EV_W       = 2;
  localparam int CTRL_HOLD  = 0;
  localparam int SHDN_FLAG  = 7;

  // Reset values.
  localparam logic [7:0]       CONFIG_RST = 8'h00;
  localparam logic [CNT_W-1:0] COUNT_RST  = 24'h000000;
  localparam logic [EV_W-1:0]  EV_RST     = 2'h0;

  // Period table in milliseconds.
  localparam int T_C1_MS  = 100;
  localparam int T_C2_MS  = 500;
  localparam int T_C3_MS  = 1_000;
  localparam int T_C4_MS  = 2_000;
  localparam int T_C5_MS  = 5_000;
  localparam int T_C6_MS  = 10_000;
  localparam int T_C7_MS  = 30_000;
  localparam int T_C8_MS  = 60_000;
  localparam int T_C9_MS  = 120_000;
  localparam int T_C10_MS = 300_000;
  localparam int T_C11_MS = 600_000;
  localparam int T_C12_MS = 1_800_000;
  localparam int T_C13_MS = 3_600_000;

  // Converts a period code to 4 kHz ticks; zero means disabled.
  function automatic logic [CNT_W-1:0] period_ticks(input logic [3:0] code);
    int ms;
    ms = 0;
    case (code)
      4'h1:    ms = T_C1_MS;
      4'h2:    ms = T_C2_MS;
      4'h3:    ms = T_C3_MS;
      4'h4:    ms = T_C4_MS;
      4'h5:    ms = T_C5_MS;
      4'h6:    ms = T_C6_MS;
      4'h7:    ms = T_C7_MS;
      4'h8:    ms = T_C8_MS;
      4'h9:    ms = T_C9_MS;
      4'hA:    ms = T_C10_MS;
      4'hB:    ms = T_C11_MS;
      4'hC:    ms = T_C12_MS;
      4'hD:    ms = T_C13_MS;
      default: ms = 0;
    endcase
    return CNT_W'(ms * TICKS_PER_MS);
  endfunction

endpackage

/* File: idle_tick_divider.sv */
`timescale 1ns/10ps
module idle_tick_divider #(
  parameter int div = idle_mon_pkg::TICK_DIV
) (
  // Clock and reset.
  input  wire logic pclk,
  input  wire logic presetn,
  // Tick out.
  idle_tick_if.src  t
);

  typedef struct packed {
    logic [idle_mon_pkg::TICK_W-1:0] cnt;
    logic                            tick;
  } div_state_s;

  localparam logic [idle_mon_pkg::TICK_W-1:0] LAST =
    idle_mon_pkg::TICK_W'(div - 1);

  div_state_s s;
  div_state_s next_s;

  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    if (s.cnt == LAST) begin
      next_s.cnt  = '0;
      next_s.tick = 1'b1;
    end else begin
      next_s.cnt = s.cnt + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign t.tick = s.tick;

  a_tick_spacing: assert property (@(posedge pclk) disable iff (!presetn)
    s.tick |=> !s.tick)
    else $error("Tick pulse lasted more than one cycle.");

endmodule

/* File: idle_tick_if.sv */
`timescale 1ns/10ps
interface idle_tick_if;
  logic tick;
  modport src (output tick);
  modport dst (input tick);
endinterface
